// ---- uart_shadow_defines.vh ----
/*
 * Shared constants of the shadow data window: bus addresses, field
 * positions, reset values and line coding figures.
 * Assumes it is included by bare name from the window, checker and testbench files.
 */
`ifndef UART_SHADOW_DEFINES_VH
`define UART_SHADOW_DEFINES_VH

// sixteen aliases, 0x40 bytes, alias 10 sits at 0x50001158
`define SHADOW_BASE      32'h50001130
`define SHADOW_SPAN      32'h00000040
`define SHADOW_ALIAS_10  32'h50001158
`define SHADOW_ALIAS_11  32'h5000115c
`define CTRL_ADDR        32'h50001170
`define STAT_ADDR        32'h50001174

// address decode results
`define SEL_NONE         2'h0
`define SEL_SHADOW       2'h1
`define SEL_CTRL         2'h2
`define SEL_STAT         2'h3

// field positions
`define BYTE_MSB         7
`define CTRL_FIFO_EN     0
`define CTRL_IR_MODE     1
`define STAT_RX_VALID    0
`define STAT_OVERRUN     1
`define STAT_TX_EMPTY    5
`define STAT_RXCNT_LSB   8
`define STAT_TXCNT_LSB   16

// reset values
`define CTRL_RESET       2'h0
`define DATA_RESET       8'h00
`define WORD_ZERO        32'h00000000

// ahb transfer type bit that marks an active transfer
`define HTRANS_ACTIVE    1

// line coding: infrared pulse is 3/16 of a bit time
`define IR_PULSE_NUM     3
`define IR_PULSE_DEN     16
`define DATA_BITS_LAST   3'h7

`endif

// ---- fifo_ram.v ----
/*
 * Small dual-port memory holding fifo entries.
 * Assumes one clock; read data come out of a register one edge after
 * the read address is presented.
 */
`timescale 1ns/1ns
`default_nettype none

module fifo_ram #(
    parameter WIDTH = 8,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             hclk,
    input  wire             hresetn,
    // write port
    input  wire             wr_en,
    input  wire [AW-1:0]    wr_addr,
    input  wire [WIDTH-1:0] wr_data,
    // read port
    input  wire [AW-1:0]    rd_addr,
    output reg  [WIDTH-1:0] rd_data
);

    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    // storage carries no reset, only its output register does
    always @(posedge hclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read keeps the array free of reset logic
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data <= {WIDTH{1'b0}};
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

`default_nettype wire

// ---- uart_shadow_data_window.v ----
/*
 * Shadow data window of a uart: ahb-lite slave with sixteen aliases of
 * the receive buffer / transmit holding register, receive and transmit
 * fifos, and a minimal serial / infrared line engine.
 * Assumes one 125 MHz bus clock, async active-low reset, a single
 * master and the line status logic reading the exported flags.
 */
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "uart_shadow_defines.vh"

// Notes on behaviour
// R01: sixteen word aliases all map to receive buffer and transmit holding.
// R02: reads return the byte received on serial or infrared input.
// R03: read data valid only while the data-valid flag is set.
// R04: fifo off: new character overwrites unread one and flags overrun.
// R05: fifo on: a read returns and consumes the oldest receive entry.
// R06: receive fifo full: incoming character dropped, contents kept, overrun.
// R07: master writes only while transmit holding empty flag is set.
// R08: written byte goes out on serial or active-low infrared output.
// R09: fifo off: one write clears the transmit holding empty flag.
// R10: fifo on: up to fifo depth characters may be written.
// R11: write while transmit fifo full is dropped, contents unchanged.
// R12: fifo off: further writes replace the pending transmit character.
// R13: upper bits read zero, ignore writes; all aliases decode alike.
module uart_shadow_data_window #(
    parameter        FIFO_DEPTH = 16,
    parameter        AW         = 4,
    parameter [15:0] BIT_CYCLES = 16'd1085
) (
    // ahb-lite slave
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // serial and infrared line
    input  wire        sin,
    input  wire        sir_in,
    output reg         sout,
    output reg         sir_out_n,
    // flags towards the line status logic
    output reg         rx_data_valid_flag,
    output reg         tx_holding_empty_flag,
    output reg         overrun_error
);

    localparam [31:0]  DEPTH_WORD = FIFO_DEPTH;
    localparam [AW:0]  FULL_COUNT = DEPTH_WORD[AW:0];
    localparam [15:0]  BIT_LAST   = BIT_CYCLES - 16'h1;
    localparam [15:0]  BIT_HALF   = BIT_CYCLES >> 1;
    localparam [31:0]  IR_RAW     = (BIT_CYCLES * `IR_PULSE_NUM)
                                    / `IR_PULSE_DEN;
    localparam [15:0]  IR_CYCLES  = (IR_RAW == 0) ? 16'h1 : IR_RAW[15:0];
    localparam [1:0]   S_IDLE     = 2'h0;
    localparam [1:0]   S_START    = 2'h1;
    localparam [1:0]   S_DATA     = 2'h2;
    localparam [1:0]   S_STOP     = 2'h3;

    // fifo occupancy step shared by both fifos
    function [AW:0] count_step;
        input [AW:0] cnt;
        input        inc;
        input        dec;
        begin
            count_step = cnt + {{AW{1'b0}}, inc} - {{AW{1'b0}}, dec};
        end
    endfunction

    // every alias offset in the 0x40 span lands on the same path [R01][R13]
    function [1:0] decode;
        input [31:0] addr;
        reg   [31:0] off;
        begin
            off = addr - `SHADOW_BASE;
            if (off < `SHADOW_SPAN)
                decode = `SEL_SHADOW;
            else if (addr == `CTRL_ADDR)
                decode = `SEL_CTRL;
            else if (addr == `STAT_ADDR)
                decode = `SEL_STAT;
            else
                decode = `SEL_NONE;
        end
    endfunction

    reg         pend_reg;
    reg         pend_write_reg;
    reg  [1:0]  pend_sel_reg;
    reg         fifo_en_reg;
    reg         ir_mode_reg;
    reg         overrun_reg;
    reg  [7:0]  rx_hold_reg;
    reg         rx_hold_valid_reg;
    reg  [AW-1:0] rx_wptr_reg;
    reg  [AW-1:0] rx_rptr_reg;
    reg  [AW:0]   rx_count_reg;
    reg  [7:0]  tx_hold_reg;
    reg         tx_hold_full_reg;
    reg  [AW-1:0] tx_wptr_reg;
    reg  [AW-1:0] tx_rptr_reg;
    reg  [AW:0]   tx_count_reg;
    reg         tx_ready_reg;
    reg  [1:0]  tx_state_reg;
    reg  [7:0]  tx_shift_reg;
    reg  [2:0]  tx_bitn_reg;
    reg  [15:0] tx_cnt_reg;
    reg         sin_s1_reg, sin_s2_reg, sir_s1_reg, sir_s2_reg;
    reg  [1:0]  rx_state_reg;
    reg  [15:0] rx_cnt_reg;
    reg  [2:0]  rx_bitn_reg;
    reg  [7:0]  rx_shift_reg;
    reg         rx_low_seen_reg;
    reg         rx_mid_low_reg;
    reg         rx_done_reg;
    reg  [7:0]  rx_char_reg;
    wire [7:0]  rx_ram_rdata;
    wire [7:0]  tx_ram_rdata;

    // data phase events, taken at the edge that ends the wait state
    wire rd_shadow = pend_reg & ~pend_write_reg & (pend_sel_reg == `SEL_SHADOW);
    wire wr_shadow = pend_reg & pend_write_reg & (pend_sel_reg == `SEL_SHADOW);
    wire wr_ctrl   = pend_reg & pend_write_reg & (pend_sel_reg == `SEL_CTRL);
    wire wr_stat   = pend_reg & pend_write_reg & (pend_sel_reg == `SEL_STAT);
    wire accept    = hsel & hready & htrans[`HTRANS_ACTIVE];
    // changing the fifo mode flushes both queues, as a fifo reset would
    wire flush     = wr_ctrl & (hwdata[`CTRL_FIFO_EN] != fifo_en_reg);

    // receive side bookkeeping
    wire rx_full   = (rx_count_reg == FULL_COUNT);
    wire rx_pop    = fifo_en_reg & rd_shadow & (rx_count_reg != 0);   // [R05]
    wire rx_push   = fifo_en_reg & rx_done_reg & (~rx_full | rx_pop); // [R06]
    wire rx_lost   = rx_done_reg & (fifo_en_reg ? (rx_full & ~rx_pop)
                   : (rx_hold_valid_reg & ~rd_shadow));          // [R04][R06]
    wire rx_valid  = fifo_en_reg ? (rx_count_reg != 0) : rx_hold_valid_reg;

    // transmit side bookkeeping
    wire tx_full   = (tx_count_reg == FULL_COUNT);
    wire tx_push   = fifo_en_reg & wr_shadow & ~tx_full;         // [R10][R11]
    wire tx_load   = (tx_state_reg == S_IDLE) & ~flush & (fifo_en_reg
                   ? (tx_ready_reg & (tx_count_reg != 0)) : tx_hold_full_reg);
    wire tx_pop    = fifo_en_reg & tx_load;
    wire thr_empty = fifo_en_reg ? (tx_count_reg == 0) : ~tx_hold_full_reg;

    // receive line as seen by the engine: low level or infrared pulse
    wire line_low  = ir_mode_reg ? sir_s2_reg : ~sin_s2_reg;
    wire rx_zero   = ir_mode_reg ? rx_low_seen_reg : rx_mid_low_reg;

    // read data mux, upper bits zero [R13]
    reg  [31:0] rd_word;
    always @* begin
        rd_word = `WORD_ZERO;
        case (pend_sel_reg)
            `SEL_SHADOW: rd_word[`BYTE_MSB:0] = fifo_en_reg ? rx_ram_rdata
                                               : rx_hold_reg;      // [R02][R05]
            `SEL_CTRL: begin
                rd_word[`CTRL_FIFO_EN] = fifo_en_reg;
                rd_word[`CTRL_IR_MODE] = ir_mode_reg;
            end
            `SEL_STAT: begin
                rd_word[`STAT_RX_VALID] = rx_valid;                 // [R03]
                rd_word[`STAT_OVERRUN]  = overrun_reg;
                rd_word[`STAT_TX_EMPTY] = thr_empty;
                rd_word[`STAT_RXCNT_LSB +: AW+1] = rx_count_reg;
                rd_word[`STAT_TXCNT_LSB +: AW+1] = tx_count_reg;
            end
            default: rd_word = `WORD_ZERO;
        endcase
    end

    // ahb slave: one wait state on every transfer so hrdata is a flop
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_reg       <= 1'b0;
            pend_write_reg <= 1'b0;
            pend_sel_reg   <= `SEL_NONE;
            hreadyout      <= 1'b1;
            hrdata         <= `WORD_ZERO;
            hresp          <= 1'b0;
        end else if (accept) begin
            pend_reg       <= 1'b1;
            pend_write_reg <= hwrite;
            pend_sel_reg   <= decode(haddr);
            hreadyout      <= 1'b0;
        end else if (pend_reg) begin
            pend_reg  <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= pend_write_reg ? `WORD_ZERO : rd_word;
        end
    end

    // control bits and sticky overrun; a new overrun beats a clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_en_reg <= 1'b0;
            ir_mode_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                fifo_en_reg <= hwdata[`CTRL_FIFO_EN];
                ir_mode_reg <= hwdata[`CTRL_IR_MODE];
            end
            if (rx_lost)
                overrun_reg <= 1'b1;                            // [R04][R06]
            else if (wr_stat & hwdata[`STAT_OVERRUN])
                overrun_reg <= 1'b0;
        end
    end

    // receive buffer: single holding byte or fifo pointers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_hold_reg       <= `DATA_RESET;
            rx_hold_valid_reg <= 1'b0;
            rx_wptr_reg       <= {AW{1'b0}};
            rx_rptr_reg       <= {AW{1'b0}};
            rx_count_reg      <= {(AW+1){1'b0}};
        end else if (flush) begin
            rx_hold_valid_reg <= 1'b0;
            rx_wptr_reg       <= {AW{1'b0}};
            rx_rptr_reg       <= {AW{1'b0}};
            rx_count_reg      <= {(AW+1){1'b0}};
        end else begin
            if (!fifo_en_reg && rx_done_reg) begin
                rx_hold_reg       <= rx_char_reg;               // [R04]
                rx_hold_valid_reg <= 1'b1;
            end else if (!fifo_en_reg && rd_shadow) begin
                rx_hold_valid_reg <= 1'b0;
            end
            if (rx_push)
                rx_wptr_reg <= rx_wptr_reg + {{(AW-1){1'b0}}, 1'b1};
            if (rx_pop)
                rx_rptr_reg <= rx_rptr_reg + {{(AW-1){1'b0}}, 1'b1};
            rx_count_reg <= count_step(rx_count_reg, rx_push, rx_pop);
        end
    end

    // transmit holding: single byte replaced by later writes, or fifo
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_hold_reg      <= `DATA_RESET;
            tx_hold_full_reg <= 1'b0;
            tx_wptr_reg      <= {AW{1'b0}};
            tx_rptr_reg      <= {AW{1'b0}};
            tx_count_reg     <= {(AW+1){1'b0}};
            tx_ready_reg     <= 1'b0;
        end else if (flush) begin
            tx_hold_full_reg <= 1'b0;
            tx_wptr_reg      <= {AW{1'b0}};
            tx_rptr_reg      <= {AW{1'b0}};
            tx_count_reg     <= {(AW+1){1'b0}};
            tx_ready_reg     <= 1'b0;
        end else begin
            if (!fifo_en_reg && wr_shadow) begin
                tx_hold_reg      <= hwdata[`BYTE_MSB:0];        // [R12]
                tx_hold_full_reg <= 1'b1;                       // [R09]
            end else if (!fifo_en_reg && tx_load) begin
                tx_hold_full_reg <= 1'b0;
            end
            if (tx_push)
                tx_wptr_reg <= tx_wptr_reg + {{(AW-1){1'b0}}, 1'b1};
            if (tx_pop)
                tx_rptr_reg <= tx_rptr_reg + {{(AW-1){1'b0}}, 1'b1};
            tx_count_reg <= count_step(tx_count_reg, tx_push, tx_pop);
            // ram read data lag one edge behind a push into an empty fifo
            tx_ready_reg <= (tx_count_reg != 0);
        end
    end

    // transmit engine: start, eight data bits lsb first, stop
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state_reg <= S_IDLE;
            tx_shift_reg <= `DATA_RESET;
            tx_bitn_reg  <= 3'h0;
            tx_cnt_reg   <= 16'h0;
        end else if (tx_load) begin
            tx_state_reg <= S_START;
            tx_shift_reg <= fifo_en_reg ? tx_ram_rdata : tx_hold_reg;
            tx_cnt_reg   <= 16'h0;
        end else if (tx_state_reg != S_IDLE) begin
            if (tx_cnt_reg != BIT_LAST) begin
                tx_cnt_reg <= tx_cnt_reg + 16'h1;
            end else begin
                tx_cnt_reg <= 16'h0;
                case (tx_state_reg)
                    S_START: begin
                        tx_state_reg <= S_DATA;
                        tx_bitn_reg  <= 3'h0;
                    end
                    S_DATA: begin
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        tx_bitn_reg  <= tx_bitn_reg + 3'h1;
                        if (tx_bitn_reg == `DATA_BITS_LAST)
                            tx_state_reg <= S_STOP;
                    end
                    default: tx_state_reg <= S_IDLE;
                endcase
            end
        end
    end

    // line outputs: plain level, or short active-low pulse per zero bit
    wire tx_bit = (tx_state_reg == S_START) ? 1'b0
                : (tx_state_reg == S_DATA) ? tx_shift_reg[0] : 1'b1;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sout      <= 1'b1;
            sir_out_n <= 1'b1;
        end else begin
            sout      <= ir_mode_reg ? 1'b1 : tx_bit;               // [R08]
            sir_out_n <= ~(ir_mode_reg & ~tx_bit
                         & (tx_cnt_reg < IR_CYCLES));               // [R08]
        end
    end

    // two-flop synchronisers on both receive pins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sin_s1_reg <= 1'b1;
            sin_s2_reg <= 1'b1;
            sir_s1_reg <= 1'b0;
            sir_s2_reg <= 1'b0;
        end else begin
            sin_s1_reg <= sin;
            sin_s2_reg <= sin_s1_reg;
            sir_s1_reg <= sir_in;
            sir_s2_reg <= sir_s1_reg;
        end
    end

    // receive engine; uart samples mid-bit, infrared takes any pulse in
    // the bit; no stop-bit framing check is made here
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_state_reg    <= S_IDLE;
            rx_cnt_reg      <= 16'h0;
            rx_bitn_reg     <= 3'h0;
            rx_shift_reg    <= `DATA_RESET;
            rx_low_seen_reg <= 1'b0;
            rx_mid_low_reg  <= 1'b0;
            rx_done_reg     <= 1'b0;
            rx_char_reg     <= `DATA_RESET;
        end else begin
            rx_done_reg <= 1'b0;
            if (rx_state_reg == S_IDLE) begin
                rx_cnt_reg      <= 16'h0;
                rx_low_seen_reg <= line_low;
                if (line_low)
                    rx_state_reg <= S_START;
            end else begin
                rx_cnt_reg      <= rx_cnt_reg + 16'h1;
                rx_low_seen_reg <= rx_low_seen_reg | line_low;
                if (rx_cnt_reg == BIT_HALF) begin
                    rx_mid_low_reg <= line_low;
                    if (rx_state_reg == S_STOP) begin
                        rx_state_reg <= S_IDLE;
                        rx_done_reg  <= 1'b1;                        // [R02]
                        rx_char_reg  <= rx_shift_reg;
                    end
                end
                if (rx_cnt_reg == BIT_LAST) begin
                    rx_cnt_reg      <= 16'h0;
                    rx_low_seen_reg <= 1'b0;
                    case (rx_state_reg)
                        S_START: begin
                            rx_state_reg <= rx_zero ? S_DATA : S_IDLE;
                            rx_bitn_reg  <= 3'h0;
                        end
                        S_DATA: begin
                            rx_shift_reg <= {~rx_zero, rx_shift_reg[7:1]};
                            rx_bitn_reg  <= rx_bitn_reg + 3'h1;
                            if (rx_bitn_reg == `DATA_BITS_LAST)
                                rx_state_reg <= S_STOP;
                        end
                        default: rx_state_reg <= S_IDLE;
                    endcase
                end
            end
        end
    end

    // flags exported to the line status logic, one cycle behind
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_data_valid_flag    <= 1'b0;
            tx_holding_empty_flag <= 1'b1;
            overrun_error         <= 1'b0;
        end else begin
            rx_data_valid_flag    <= rx_valid;                       // [R03]
            tx_holding_empty_flag <= thr_empty;                 // [R09][R10]
            overrun_error         <= overrun_reg;
        end
    end

    // receive and transmit fifo storage
    fifo_ram #(.WIDTH(8), .AW(AW)) rx_ram (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (rx_push),
        .wr_addr (rx_wptr_reg),
        .wr_data (rx_char_reg),
        .rd_addr (rx_rptr_reg),
        .rd_data (rx_ram_rdata)
    );

    fifo_ram #(.WIDTH(8), .AW(AW)) tx_ram (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (tx_push),
        .wr_addr (tx_wptr_reg),
        .wr_data (hwdata[`BYTE_MSB:0]),
        .rd_addr (tx_rptr_reg),
        .rd_data (tx_ram_rdata)
    );

endmodule

`default_nettype wire

// ---- uart_shadow_props.sv ----
/*
 * Checker of the shadow data window: bus timing and flag relations.
 * Assumes it is bound to uart_shadow_data_window with one clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "uart_shadow_defines.vh"
module uart_shadow_props (
    // bus side
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // line and flags
    input wire logic        sir_out_n,
    input wire logic        rx_data_valid_flag,
    input wire logic        tx_holding_empty_flag,
    input wire logic        overrun_error
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       take;
    logic       in_win;
    logic       rd_sh_reg;
    logic       ctl_reg;
    logic [1:0] mode_reg;
    assign take = hsel && hready && htrans[1];
    assign in_win = haddr >= `SHADOW_BASE
                    && haddr < `SHADOW_BASE + `SHADOW_SPAN;
    // mode is copied from control writes, since the checker sees ports only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_sh_reg <= 1'b0;
            ctl_reg <= 1'b0;
            mode_reg <= `CTRL_RESET;
        end else begin
            if (take) begin
                rd_sh_reg <= !hwrite && in_win;
            end
            ctl_reg <= take && hwrite && haddr == `CTRL_ADDR;
            if (ctl_reg) begin
                mode_reg <= hwdata[1:0];
            end
        end
    end
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_one_wait: assert property (take |=> !hreadyout ##1 hreadyout)
        else $error("wait state count wrong");
    a_wait_short: assert property (!hreadyout |=> hreadyout)
        else $error("wait longer than one cycle");
    a_upper_zero: assert property (
        $rose(hreadyout) && rd_sh_reg |-> hrdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_rdata_hold: assert property (!$rose(hreadyout) |-> $stable(hrdata))
        else $error("read data moved between reads");
    a_write_clears: assert property (take && hwrite && in_win
        && !mode_reg[0] && tx_holding_empty_flag
        |-> ##[1:6] !tx_holding_empty_flag)
        else $error("write left empty flag set");
    a_overrun_cause: assert property (
        $rose(overrun_error) |-> $past(rx_data_valid_flag))
        else $error("overrun without unread data");
    a_ir_quiet: assert property (
        !mode_reg[1] && !$past(mode_reg[1]) |-> sir_out_n)
        else $error("infrared output active in uart mode");
endmodule
bind uart_shadow_data_window uart_shadow_props u_props (.*);
`default_nettype wire

// ---- uart_line_partner.sv ----
/*
 * Remote uart on the serial line: sends frames on request, decodes
 * frames from the design. Assumes 8N1 framing, lsb first.
 */
`timescale 1ns/1ns
`default_nettype none
module uart_line_partner #(
    parameter int BIT_CYCLES = 16
) (
    // clock
    input  wire logic       hclk,
    // line
    input  wire logic       sout,
    output var  logic       sin,
    output var  logic       sir_in,
    // decoded byte, strobe lasts one cycle
    output var  logic [7:0] heard,
    output var  logic       heard_stb
);
    // idle high line; infrared input stays dark in uart mode
    initial begin
        sin = 1'b1;
        sir_in = 1'b0;
        heard = 8'h00;
        heard_stb = 1'b0;
    end
    // one frame: start, data lsb first, stop
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        @(posedge hclk);
        for (int i = 0; i < 10; i++) begin
            sin <= f[i];
            repeat (BIT_CYCLES) @(posedge hclk);
        end
    endtask
    // sample mid bit; no resync, so only clean frames are decoded
    always begin : listen
        logic [7:0] d;
        @(negedge sout);
        repeat (BIT_CYCLES / 2) @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge hclk);
            d[i] = sout;
        end
        repeat (BIT_CYCLES) @(posedge hclk);
        heard <= d;
        heard_stb <= 1'b1;
        @(posedge hclk);
        heard_stb <= 1'b0;
    end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
/*
 * Testbench of the shadow data window: ahb-lite master, remote uart.
 * Assumes a short bit time.
 */
`timescale 1ns/1ns
`default_nettype none
`include "uart_shadow_defines.vh"
`define CHK(n, e, g) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("BAD %s exp %h got %h", n, e, g); \
    end \
end
module tb_top;
    localparam int BITC = 16;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dph = 0;
    logic [31:0] haddr = 0, hwdata = 0, w, e;
    logic [1:0]  htrans = 0;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, sin, sir_in, sout, sir_out_n;
    wire         rxv, txe, ovr, heard_stb;
    wire  [7:0]  heard;
    int          failures = 0, check_count = 0;
    logic [31:0] rd_q[$];
    logic [7:0]  tx_q[$], b[17], e8;
    always #4 hclk = ~hclk;
    uart_shadow_data_window #(.FIFO_DEPTH(16), .AW(4),
        .BIT_CYCLES(16'd16)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sin(sin), .sir_in(sir_in), .sout(sout),
        .sir_out_n(sir_out_n), .rx_data_valid_flag(rxv),
        .tx_holding_empty_flag(txe), .overrun_error(ovr));
    uart_line_partner #(.BIT_CYCLES(BITC)) far (.hclk(hclk), .sout(sout),
        .sin(sin), .sir_in(sir_in), .heard(heard), .heard_stb(heard_stb));
    // single transfer; the address phase holds until hready is seen high
    task automatic bus(input logic wr, input logic [31:0] a, d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        dph <= !wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        dph <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, x);
        rd_q.push_back(x);
        bus(1'b0, a, 32'h00000000);
    endtask
    // a frame ends after its stop bit, so data is in by then
    task automatic rx(input logic [7:0] x);
        far.send(x);
        repeat (4) @(posedge hclk);
    endtask
    // read data is due where the data phase completes
    always @(posedge hclk) begin
        if (dph && hreadyout) begin
            e = rd_q.pop_front();
            `CHK("hrdata", e, hrdata)
        end
        if (heard_stb) begin
            e8 = tx_q.pop_front();
            `CHK("line byte", e8, heard)
        end
    end
    task automatic conclude;
        if (failures == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge hclk);
        failures++;
        conclude;
    end
    initial begin
        void'($urandom(28288));
        for (int i = 0; i < 17; i++) b[i] = $urandom;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        `CHK("sout", 1'b1, sout)
        `CHK("tx empty", 1'b1, txe)
        `CHK("rx valid", 1'b0, rxv)
        // fifo off: the second pending byte is replaced by the third
        w = $urandom;
        bus(1'b1, `SHADOW_ALIAS_10, {w[31:8], b[0]});
        tx_q.push_back(b[0]);
        bus(1'b1, `SHADOW_ALIAS_11, {24'h0, b[1]});
        repeat (2) @(posedge hclk);
        `CHK("tx empty", 1'b0, txe)
        bus(1'b1, `SHADOW_ALIAS_10, {24'h0, b[2]});
        tx_q.push_back(b[2]);
        repeat (30 * BITC) @(posedge hclk);
        // fifo off receive, then an unread byte overwritten
        rx(b[3]);
        `CHK("rx valid", 1'b1, rxv)
        rd(`SHADOW_BASE + 4 * ($urandom % 16), {24'h0, b[3]});
        repeat (2) @(posedge hclk);
        `CHK("rx valid", 1'b0, rxv)
        rx(b[4]);
        rx(b[5]);
        `CHK("overrun", 1'b1, ovr)
        rd(`SHADOW_ALIAS_11, {24'h0, b[5]});
        bus(1'b1, `STAT_ADDR, 32'h00000002);
        rd(32'h50001100, `WORD_ZERO);
        `CHK("overrun", 1'b0, ovr)
        // fifo on: sixteen fill it, the seventeenth is lost
        bus(1'b1, `CTRL_ADDR, 32'h00000001);
        for (int i = 0; i < 17; i++) rx(b[i]);
        `CHK("overrun", 1'b1, ovr)
        for (int i = 0; i < 16; i++)
            rd(`SHADOW_BASE + 4 * i, {24'h0, b[i]});
        repeat (2) @(posedge hclk);
        `CHK("rx valid", 1'b0, rxv)
        // one byte in the shifter, sixteen queued, the last is dropped
        for (int i = 0; i < 18; i++) begin
            w = $urandom;
            bus(1'b1, `SHADOW_BASE + 4 * (i % 16), w);
            if (i < 17) tx_q.push_back(w[7:0]);
        end
        for (int k = 0; k < 20000 && tx_q.size() > 0; k++) @(posedge hclk);
        repeat (20 * BITC) @(posedge hclk);
        `CHK("bytes left", 0, tx_q.size())
        conclude;
    end
endmodule
`default_nettype wire
